// ### design/spm_pkg.sv
package spm_pkg;
	typedef struct packed {
		logic [3:0] adr;
		logic [31:0] dat;
		logic we;
		logic [3:0] sel;
		logic cyc;
		logic stb;
	} spm_wb_req_s;
	typedef enum logic [2:0] {
		SPM_CLK_GPIO,
		SPM_CLK_IRQ,
		SPM_CLK_OUT,
		SPM_CLK_IN,
		SPM_CLK_BAD
	} spm_clk_fn_e;
endpackage

// ### design/spm_regs.svh
`ifndef SPM_REGS_SVH
`define SPM_REGS_SVH
// ----------------------------------------
// Register map (word byte addresses)
// ----------------------------------------
`define SPM_ADDR_CTL 4'h0
`define SPM_ADDR_CTL2 4'h4
`define SPM_ADDR_PORTF 4'h8
`define SPM_ADDR_STAT 4'hC
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPM_B_CH2_SEL 5
`define SPM_B_CH1_SEL 4
`define SPM_B_CH2_TXI 3
`define SPM_B_CH2_RXI 2
`define SPM_B_CH1_TXI 1
`define SPM_B_CH1_RXI 0
`define SPM_B_CH3_SEL 4
`define SPM_B_CH3_TXI 1
`define SPM_B_CH3_RXI 0
`define SPM_B_PF_CAPT 0
`define SPM_B_PF_IRQ 1
`define SPM_B_PF_P9IRQ 2
`define SPM_B_PF_ASSIGN 3
`define SPM_B_PF_DIR0 4
`define SPM_B_PF_DIR1 5
// ----------------------------------------
// Reserved bits and reset values
// ----------------------------------------
`define SPM_CTL_RSVD 8'hC0
`define SPM_CTL2_RSVD 8'hEC
`define SPM_RESET_BITS 8'h00
`endif

// ### design/spm_sync2.sv
`timescale 1ns/10ps
`default_nettype none
module spm_sync2 (
	input wire logic clock,
	input wire logic reset,
	input wire logic [3:0] async_in,
	output logic [3:0] sync_out
);
	logic [3:0] meta_q;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			meta_q <= 4'h0;
			sync_out <= 4'h0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### design/spm_top.sv
// Contract
// (R1) Control bit 5 routes channel 2 transmit to its shared pin.
// (R2) Software sets channel 2 pin select before enabling its transmitter.
// (R3) Control bit 4 routes channel 1 transmit or infrared transmit to pin.
// (R4) Software sets channel 1 pin select before enabling its transmitter.
// (R5) Control bit 3 inverts channel 2 transmit level.
// (R6) Control bit 2 inverts channel 2 receive level.
// (R7) Control bit 1 inverts channel 1 transmit, plain or infrared.
// (R8) Control bit 0 inverts channel 1 receive, plain or infrared.
// (R9) Reserved bits read one and ignore writes in both registers.
// (R10) Inversion changes act on pin data right after the write.
// (R11) Software changes the registers only while line data is ignored.
// (R12) Second control bit 4 routes channel 3 transmit to its pin.
// (R13) Software sets channel 3 pin select before enabling its transmitter.
// (R14) Second control bit 1 inverts channel 3 transmit level.
// (R15) Second control bit 0 inverts channel 3 receive level.
// (R16) Timer pin is capture input when mode bit set, else GPIO.
// (R17) Clock pin: interrupt first, then GPIO, then mode and clock bits.
// (R18) All select and inversion bits reset to zero.
//
// The Wishbone slave port and the register addresses were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"
module spm_top (
	input wire logic clock,
	input wire logic reset,
	input wire spm_pkg::spm_wb_req_s wb_req,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic ch1_tx_data,
	input wire logic ch2_tx_data,
	input wire logic ch3_tx_data,
	input wire logic ch1_ir_enable,
	input wire logic ch1_ir_tx_data,
	input wire logic ch1_sync_mode,
	input wire logic clock_enable_hi,
	input wire logic clock_enable_lo,
	input wire logic ch1_sck_out,
	input wire logic ch1_transmit_pin_gpio,
	input wire logic ch2_transmit_pin_gpio,
	input wire logic ch3_transmit_pin_gpio,
	input wire logic ch1_receive_pin,
	input wire logic ch2_receive_pin,
	input wire logic ch3_receive_pin,
	input wire logic ch1_serial_clock_pin_i,
	output logic ch1_transmit_pin,
	output logic ch2_transmit_pin,
	output logic ch3_transmit_pin,
	output logic ch1_rx_data,
	output logic ch2_rx_data,
	output logic ch3_rx_data,
	output logic ch1_serial_clock_pin_o,
	output logic ch1_serial_clock_pin_oe,
	output logic ch1_sck_in,
	output logic external_interrupt_input,
	output logic timer_capture_input,
	output logic pf0_oe,
	output logic clock_pin_prohibited
);
	// ----------------------------------------
	// Register bus
	// ----------------------------------------
	logic [7:0] ctl_q;
	logic [7:0] ctl2_q;
	logic [7:0] portf_q;
	logic ack_q;
	logic [31:0] rdat_q;
	// A request is taken once; the pending acknowledge masks the held cycle.
	wire bus_req = wb_req.cyc && wb_req.stb && !ack_q;
	wire bus_wr = bus_req && wb_req.we && wb_req.sel[0];
	wire hit_ctl = wb_req.adr == `SPM_ADDR_CTL;
	wire hit_ctl2 = wb_req.adr == `SPM_ADDR_CTL2;
	wire hit_portf = wb_req.adr == `SPM_ADDR_PORTF;
	wire hit_stat = wb_req.adr == `SPM_ADDR_STAT;
	wire [7:0] wbyte = wb_req.dat[7:0];
	logic [7:0] stat_w;
	// Reserved bits are forced to one on read only, so no storage is wasted.
	wire [7:0] ctl_rd = ctl_q | `SPM_CTL_RSVD; // R9
	wire [7:0] ctl2_rd = ctl2_q | `SPM_CTL2_RSVD; // R9
	wire [7:0] rsel = hit_ctl ? ctl_rd :
		hit_ctl2 ? ctl2_rd :
		hit_portf ? portf_q :
		hit_stat ? stat_w : 8'h00;
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ctl_q <= `SPM_RESET_BITS; // R18
			ctl2_q <= `SPM_RESET_BITS; // R18
			portf_q <= `SPM_RESET_BITS;
		end else if (bus_wr) begin
			if (hit_ctl)
				ctl_q <= wbyte & ~`SPM_CTL_RSVD; // R9
			if (hit_ctl2)
				ctl2_q <= wbyte & ~`SPM_CTL2_RSVD; // R9
			if (hit_portf)
				portf_q <= wbyte;
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ack_q <= 1'b0;
			rdat_q <= 32'h0000_0000;
		end else begin
			ack_q <= bus_req;
			rdat_q <= {24'h00_0000, rsel};
		end
	end
	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	// ----------------------------------------
	// Pin input synchronisers
	// ----------------------------------------
	logic [3:0] pins_s;
	spm_sync2 u_sync (
		.clock(clock),
		.reset(reset),
		.async_in({ch1_serial_clock_pin_i, ch3_receive_pin,
			ch2_receive_pin, ch1_receive_pin}),
		.sync_out(pins_s)
	);
	// ----------------------------------------
	// Transmit routing and inversion
	// ----------------------------------------
	wire ch1_sel = ctl_q[`SPM_B_CH1_SEL];
	wire ch2_sel = ctl_q[`SPM_B_CH2_SEL];
	wire ch3_sel = ctl2_q[`SPM_B_CH3_SEL];
	wire ch1_txi = ctl_q[`SPM_B_CH1_TXI];
	wire ch2_txi = ctl_q[`SPM_B_CH2_TXI];
	wire ch3_txi = ctl2_q[`SPM_B_CH3_TXI];
	// Plain and infrared data share one inverter, as the pin does.
	wire ch1_src = ch1_ir_enable ? ch1_ir_tx_data : ch1_tx_data;
	wire ch1_tx_d = ch1_sel ?
		ch1_src ^ ch1_txi : ch1_transmit_pin_gpio; // R3 R7
	wire ch2_tx_d = ch2_sel ?
		ch2_tx_data ^ ch2_txi : ch2_transmit_pin_gpio; // R1 R5
	wire ch3_tx_d = ch3_sel ?
		ch3_tx_data ^ ch3_txi : ch3_transmit_pin_gpio; // R12 R14
	// Receive inversion applies to the synchronised pin level.
	// A setting change flips data in flight; software must mask the line.
	wire ch1_rx_d = pins_s[0] ^ ctl_q[`SPM_B_CH1_RXI]; // R8
	wire ch2_rx_d = pins_s[1] ^ ctl_q[`SPM_B_CH2_RXI]; // R6
	wire ch3_rx_d = pins_s[2] ^ ctl2_q[`SPM_B_CH3_RXI]; // R15
	// ----------------------------------------
	// Port F pin functions
	// ----------------------------------------
	wire capt_mode = portf_q[`SPM_B_PF_CAPT];
	wire irq_sel = portf_q[`SPM_B_PF_IRQ] && !portf_q[`SPM_B_PF_P9IRQ];
	wire assign_sel = portf_q[`SPM_B_PF_ASSIGN];
	wire dir0 = portf_q[`SPM_B_PF_DIR0];
	wire dir1 = portf_q[`SPM_B_PF_DIR1];
	spm_pkg::spm_clk_fn_e clk_fn;
	always_comb begin
		clk_fn = spm_pkg::SPM_CLK_GPIO;
		if (irq_sel)
			clk_fn = spm_pkg::SPM_CLK_IRQ; // R17
		else if (!assign_sel)
			clk_fn = spm_pkg::SPM_CLK_GPIO; // R17
		else if (!ch1_sync_mode) begin
			if (clock_enable_hi)
				clk_fn = clock_enable_lo ? spm_pkg::SPM_CLK_BAD :
					spm_pkg::SPM_CLK_IN;
			else if (clock_enable_lo)
				clk_fn = spm_pkg::SPM_CLK_OUT;
		end else begin
			if (clock_enable_lo)
				clk_fn = spm_pkg::SPM_CLK_BAD;
			else
				clk_fn = clock_enable_hi ? spm_pkg::SPM_CLK_IN :
					spm_pkg::SPM_CLK_OUT;
		end
	end
	wire sck_oe_d = (clk_fn == spm_pkg::SPM_CLK_OUT) ||
		((clk_fn == spm_pkg::SPM_CLK_GPIO) && dir1);
	wire sck_o_d = (clk_fn == spm_pkg::SPM_CLK_OUT) ? ch1_sck_out : 1'b0;
	wire is_clk_in = clk_fn == spm_pkg::SPM_CLK_IN;
	wire is_irq = clk_fn == spm_pkg::SPM_CLK_IRQ;
	wire is_bad = clk_fn == spm_pkg::SPM_CLK_BAD;
	assign stat_w = {4'h0, is_bad, is_irq, is_clk_in, sck_oe_d};
	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ch1_transmit_pin <= 1'b0;
			ch2_transmit_pin <= 1'b0;
			ch3_transmit_pin <= 1'b0;
			ch1_rx_data <= 1'b0;
			ch2_rx_data <= 1'b0;
			ch3_rx_data <= 1'b0;
		end else begin
			ch1_transmit_pin <= ch1_tx_d; // R10
			ch2_transmit_pin <= ch2_tx_d; // R10
			ch3_transmit_pin <= ch3_tx_d; // R10
			ch1_rx_data <= ch1_rx_d;
			ch2_rx_data <= ch2_rx_d;
			ch3_rx_data <= ch3_rx_d;
		end
	end
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			ch1_serial_clock_pin_o <= 1'b0;
			ch1_serial_clock_pin_oe <= 1'b0;
			ch1_sck_in <= 1'b0;
			external_interrupt_input <= 1'b0;
			timer_capture_input <= 1'b0;
			pf0_oe <= 1'b0;
			clock_pin_prohibited <= 1'b0;
		end else begin
			ch1_serial_clock_pin_o <= sck_o_d;
			ch1_serial_clock_pin_oe <= sck_oe_d; // R17
			ch1_sck_in <= is_clk_in & pins_s[3];
			external_interrupt_input <= is_irq & pins_s[3];
			timer_capture_input <= capt_mode & pins_s[3]; // R16
			pf0_oe <= !capt_mode && dir0; // R16
			clock_pin_prohibited <= is_bad;
		end
	end
	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_ch2_tx_route: assert property (@(posedge clock) disable iff (reset) // R1
		ch2_sel |=> ch2_transmit_pin ==
			($past(ch2_tx_data) ^ $past(ch2_txi)))
		else $error("channel 2 transmit pin wrong");
	a_ch1_tx_route: assert property (@(posedge clock) disable iff (reset) // R3
		(ch1_sel && !ch1_ir_enable) |=> ch1_transmit_pin ==
			($past(ch1_tx_data) ^ $past(ch1_txi)))
		else $error("channel 1 transmit pin wrong");
	a_ch1_ir_inv: assert property (@(posedge clock) disable iff (reset) // R7
		(ch1_sel && ch1_ir_enable && ch1_txi)
			|=> ch1_transmit_pin != $past(ch1_ir_tx_data))
		else $error("infrared transmit not inverted");
	a_ch3_tx_route: assert property (@(posedge clock) disable iff (reset) // R12
		!ch3_sel |=> ch3_transmit_pin == $past(ch3_transmit_pin_gpio))
		else $error("channel 3 pin not general I/O");
	a_ch2_rx_inv: assert property (@(posedge clock) disable iff (reset) // R6
		ch2_rx_data == ($past(pins_s[1]) ^ $past(ctl_q[`SPM_B_CH2_RXI])))
		else $error("channel 2 receive inversion wrong");
	a_ch1_rx_inv: assert property (@(posedge clock) disable iff (reset) // R8
		ch1_rx_data == ($past(pins_s[0]) ^ $past(ctl_q[`SPM_B_CH1_RXI])))
		else $error("channel 1 receive inversion wrong");
	a_ch3_rx_inv: assert property (@(posedge clock) disable iff (reset) // R15
		ch3_rx_data == ($past(pins_s[2]) ^ $past(ctl2_q[`SPM_B_CH3_RXI])))
		else $error("channel 3 receive inversion wrong");
	a_ch3_tx_inv: assert property (@(posedge clock) disable iff (reset) // R14
		ch3_sel |=> ch3_transmit_pin ==
			($past(ch3_tx_data) ^ $past(ch3_txi)))
		else $error("channel 3 transmit inversion wrong");
	a_ch2_tx_gpio: assert property (@(posedge clock) disable iff (reset) // R1
		!ch2_sel |=> ch2_transmit_pin == $past(ch2_transmit_pin_gpio))
		else $error("channel 2 pin not general I/O");
	a_ch1_tx_gpio: assert property (@(posedge clock) disable iff (reset) // R3
		!ch1_sel |=> ch1_transmit_pin == $past(ch1_transmit_pin_gpio))
		else $error("channel 1 pin not general I/O");
	a_rsvd_ones: assert property (@(posedge clock) disable iff (reset) // R9
		(ctl_rd[7:6] == 2'b11) && (ctl2_rd[7:5] == 3'b111)
			&& (ctl2_rd[3:2] == 2'b11))
		else $error("reserved bits not one");
	a_rsvd_unstored: assert property (@(posedge clock) disable iff (reset) // R9
		(ctl_q[7:6] == 2'b00) && (ctl2_q[7:5] == 3'b000)
			&& (ctl2_q[3:2] == 2'b00))
		else $error("reserved bits took a write");
	a_inv_immediate: assert property (@(posedge clock) disable iff (reset) // R10
		(bus_wr && hit_ctl2) |=> ##1 ch3_transmit_pin ==
			($past(ch3_sel) ? ($past(ch3_tx_data) ^
			$past(ch3_txi)) : $past(ch3_transmit_pin_gpio)))
		else $error("inversion change late");
	a_ack_pulse: assert property (@(posedge clock) disable iff (reset) // local Wishbone port
		wb_ack_o |=> !wb_ack_o)
		else $error("acknowledge longer than one cycle");
	a_clk_bad: assert property (@(posedge clock) disable iff (reset) // R17
		is_bad |=> clock_pin_prohibited && !ch1_serial_clock_pin_oe)
		else $error("prohibited clock setting drives the pin");
	a_clk_gpio: assert property (@(posedge clock) disable iff (reset) // R17
		(!irq_sel && !assign_sel) |=>
			ch1_serial_clock_pin_oe == $past(dir1))
		else $error("clock pin ignores its direction bit");
	a_timer_capture_input_value: assert property (@(posedge clock) disable iff (reset) // R16
		capt_mode |=> timer_capture_input == $past(pins_s[3]))
		else $error("timer capture input wrong");
	a_irq_priority: assert property (@(posedge clock) disable iff (reset) // R17
		irq_sel |=> !ch1_serial_clock_pin_oe && !ch1_sck_in)
		else $error("interrupt did not take the pin");
	a_timer_capture_input_input: assert property (@(posedge clock) disable iff (reset) // R16
		capt_mode |=> !pf0_oe)
		else $error("timer pin driven in capture mode");
endmodule
`default_nettype wire

// ### tb/serial_pin_mux_inversion_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "spm_regs.svh"
module serial_pin_mux_inversion_tb;
	logic clock, reset, ack, ire, ird;
	spm_pkg::spm_wb_req_s req;
	logic [31:0] rd, q;
	logic [2:0] txd, gp, rxp, txp, rxd, et, ek;
	logic [5:0] ck;
	logic [7:0] a, b;
	logic [8:0] h;
	logic [6:0] pf_o;
	logic [4:0] ex;
	logic [15:0] r;
	int n_errors, n_tests, cyc_n;
	spm_top i_dut(.clock(clock), .reset(reset), .wb_req(req),
		.wb_dat_o(rd), .wb_ack_o(ack), .ch1_tx_data(txd[0]),
		.ch2_tx_data(txd[1]), .ch3_tx_data(txd[2]), .ch1_ir_enable(ire),
		.ch1_ir_tx_data(ird), .ch1_sync_mode(ck[0]),
		.clock_enable_hi(ck[1]), .clock_enable_lo(ck[2]),
		.ch1_sck_out(ck[3]), .ch1_transmit_pin_gpio(gp[0]),
		.ch2_transmit_pin_gpio(gp[1]), .ch3_transmit_pin_gpio(gp[2]),
		.ch1_receive_pin(rxp[0]), .ch2_receive_pin(rxp[1]),
		.ch3_receive_pin(rxp[2]), .ch1_serial_clock_pin_i(ck[4]),
		.ch1_transmit_pin(txp[0]), .ch2_transmit_pin(txp[1]),
		.ch3_transmit_pin(txp[2]), .ch1_rx_data(rxd[0]),
		.ch2_rx_data(rxd[1]), .ch3_rx_data(rxd[2]),
		.ch1_serial_clock_pin_o(pf_o[0]),
		.ch1_serial_clock_pin_oe(pf_o[1]),
		.ch1_sck_in(pf_o[2]), .external_interrupt_input(pf_o[3]),
		.timer_capture_input(pf_o[4]), .pf0_oe(pf_o[5]),
		.clock_pin_prohibited(pf_o[6]));
	spm_partner i_far(.clock(clock), .reset(reset), .rx_pins(rxp));
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [2:0] exp_tx(input logic [7:0] c, d,
		input logic [2:0] t, g, input logic ie, id);
		logic s;
		s = ie ? id : t[0];
		return {d[4] ? t[2] ^ d[1] : g[2], c[5] ? t[1] ^ c[3] : g[1],
			c[4] ? s ^ c[1] : g[0]};
	endfunction
	// Returns {clock out, prohibited, interrupt, clock in, clock pin oe}.
	function automatic logic [4:0] exp_clk(input logic [7:0] p,
		input logic m, hi, lo);
		logic irq, ser;
		irq = p[1] & ~p[2];
		ser = ~irq & p[3];
		return {ser & ~hi & (m ? ~lo : lo), ser & lo & (m | hi), irq,
			ser & hi & ~lo, ser ? ~hi & (m ? ~lo : lo) : ~irq & p[5]};
	endfunction
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_tests++;
		if (s !== e) begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wb(input logic [3:0] ad, input logic w,
		input logic [7:0] d, output logic [31:0] o);
		int t;
		@(posedge clock);
		req <= '{ad, {24'h000000, d}, w, 4'hF, 1'b1, 1'b1};
		t = 0;
		do begin
			@(posedge clock);
			t++;
		end while (ack !== 1'b1 && t < 50);
		if (t >= 50) begin
			n_errors++;
			give_verdict;
		end
		o = rd;
		req.cyc <= 1'b0;
		req.stb <= 1'b0;
	endtask
	task automatic give_verdict;
		$display("comparisons %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		clock = 1'b0;
		forever #2 clock = ~clock;
	end
	always @(posedge clock) begin
		cyc_n++;
		if (cyc_n == 3000) begin
			n_errors++;
			give_verdict;
		end
	end
	initial begin
		reset = 1'b1;
		req = '0;
		{txd, gp, ire, ird, ck} = '0;
		r = 16'h003B;
		h = '0;
		et = '0;
		repeat (3) @(posedge clock);
		reset <= 1'b0;
		wb(`SPM_ADDR_CTL, 1'b0, 8'h00, q);
		chk("ctl_reset", q, 32'h000000C0);
		wb(`SPM_ADDR_CTL2, 1'b0, 8'h00, q);
		chk("ctl2_reset", q, 32'h000000EC);
		wb(4'h2, 1'b0, 8'h00, q);
		chk("unmapped", q, 32'h00000000);
		for (int i = 0; i < 8; i++) begin
			r = lfsr(r);
			wb(`SPM_ADDR_CTL, 1'b1, r[7:0], q);
			wb(`SPM_ADDR_CTL2, 1'b1, r[15:8], q);
			wb(`SPM_ADDR_CTL, 1'b0, 8'h00, q);
			chk("ctl", q, {24'h000000, r[7:0] | 8'hC0});
			wb(`SPM_ADDR_CTL2, 1'b0, 8'h00, q);
			chk("ctl2", q, {24'h000000, r[15:8] | 8'hEC});
		end
		$display("register test done");
		for (int k = 0; k < 8; k++) begin
			r = lfsr(r);
			a = k == 0 ? 8'h02 : r[7:0];
			@(posedge clock);
			ck <= {1'b0, 1'b1, r[8], r[9], r[10], r[11]};
			wb(`SPM_ADDR_PORTF, 1'b1, a, q);
			repeat (4) @(posedge clock);
			wb(`SPM_ADDR_STAT, 1'b0, 8'h00, q);
			ex = exp_clk(a, r[11], r[10], r[9]);
			chk("clk_status", q, {28'h0000000, ex[3:0]});
			chk("port_f_pins", pf_o, {ex[3], !a[0] && a[4], a[0], ex[2],
				ex[1], ex[0], ex[4] && r[8]});
		end
		$display("port F test done");
		for (int s = 0; s < 6; s++) begin
			r = lfsr(r);
			a = s == 0 ? 8'h00 : s == 1 ? 8'hFF : r[7:0];
			b = s == 0 ? 8'h00 : s == 1 ? 8'hFF : r[15:8];
			wb(`SPM_ADDR_CTL, 1'b1, a, q);
			wb(`SPM_ADDR_CTL2, 1'b1, b, q);
			for (int i = 0; i < 24; i++) begin
				@(posedge clock);
				r = lfsr(r);
				{txd, gp, ire, ird, ck} <= r[13:0];
				ek = exp_tx(a, b, r[13:11], r[10:8], r[7], r[6]);
				#1;
				if (i > 0) chk("tx_pins", txp, et);
				if (i > 2) chk("rx_data", rxd, h[8:6]);
				et = ek;
				h = {h[5:0], rxp ^ {b[0], a[2], a[0]}};
			end
		end
		$display("pin test done");
		give_verdict;
	end
endmodule
`default_nettype wire

// ### tb/spm_partner.sv
`timescale 1ns/10ps
`default_nettype none
module spm_partner (
	input wire logic clock,
	input wire logic reset,
	output logic [2:0] rx_pins
);
	logic [7:0] s_q;
	// The lines rest at mark level in reset, then take a new LFSR value every cycle.
	// This means a design that holds a stale value cannot pass.
	always_ff @(posedge clock or posedge reset) begin
		if (reset) begin
			s_q <= 8'hA5;
			rx_pins <= 3'h7;
		end else begin
			s_q <= {s_q[6:0], s_q[7] ^ s_q[5] ^ s_q[4] ^ s_q[3]};
			rx_pins <= s_q[2:0];
		end
	end
endmodule
`default_nettype wire
